// File: src/ppri_consts.svh
// Offsets, bit positions, reset values and codes of the printer port register interface.
`ifndef PPRI_CONSTS_SVH
`define PPRI_CONSTS_SVH

// ==========================================================================
// Register offsets on the two address lines
`define PPRI_OFS_IOSEL       2'h0
`define PPRI_OFS_STATUS      2'h1
`define PPRI_OFS_DRIVE       2'h2

// ==========================================================================
// Status register bit positions
`define PPRI_ST_BUSY_N       7
`define PPRI_ST_ACK          6
`define PPRI_ST_PAPER_END    5
`define PPRI_ST_SELECTED     4
`define PPRI_ST_FAULT        3
`define PPRI_ST_IRQ_IDLE     2

// ==========================================================================
// Drive and readback register bit positions
`define PPRI_CT_DIR_IN       5
`define PPRI_CT_IRQ_EN       4
`define PPRI_CT_SELECT_IN    3
`define PPRI_CT_INIT         2
`define PPRI_CT_AUTO_FEED    1
`define PPRI_CT_STROBE       0

// ==========================================================================
// Constant bits, direction codes and reset values
`define PPRI_ST_ONES         2'h3
`define PPRI_CMD_ONES        3'h7
`define PPRI_IOSEL_INPUT     8'hAA
`define PPRI_IOSEL_OUTPUT    8'h55
`define PPRI_RST_LINE_N      1'h1
`define PPRI_RST_INIT        1'h0
`define PPRI_RST_BIT         1'h0
`define PPRI_RST_BYTE        8'h00
`define PPRI_RST_STROBES     3'h7

`endif

// File: src/ppri_pkg.sv
// Types shared by the printer port register interface.
package ppri_pkg;

  typedef struct packed {
    logic       strobe_n;
    logic       auto_feed_n;
    logic       init;
    logic       select_in_n;
    logic       irq_en;
    logic       dir_bit;
    logic       iosel_in;
    logic       pending;
    logic       irq_out;
    logic       data_in_mode;
    logic [7:0] rd_data;
    logic       rd_oe;
  } ppri_state_s;

endpackage

// File: src/ppri_fall_detect.sv
// Falling edge detector for a group of synchronous level inputs.
`timescale 1ns/10ps
`include "ppri_consts.svh"

module ppri_fall_detect #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] level,
  output      logic [W-1:0] fall
);

  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  // ========================================================================
  // Previous level
  // Idle level is high for every watched line, so a line held low through
  // reset reports a falling edge from reset until the first clock after release.
  always_comb
  begin
    prev_d = level;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_q <= '1;
    end
    else
    begin
      prev_q <= prev_d;
    end
  end

  // ========================================================================
  // Per-bit edge
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    assign fall[i] = prev_q[i] & ~level[i];
  end

endmodule

// File: src/ppri_regs.sv
// Printer port register interface: status, readback and drive registers.
//
// What this block does
// - Status reads busy-inverted, ack, paper, select, fault, irq
// - Status bit 2 low while interrupt pending, with SW_DIR_VARIANT set
// - Readback: ones on top, enable, four line states
// - Drive register: direction, interrupt gate, four lines
// - Ack falling edge marks interrupt pending
// - Status read clears pending and interrupt output, unless an ack falling edge comes in the same cycle
// - Drive write updates lines and mask at once
// - Mode pin low: AA selects input, 55 output
`timescale 1ns/10ps
`include "ppri_consts.svh"

module ppri_regs #(
  parameter bit SW_DIR_VARIANT = 1'b1
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic [1:0] addr,
  input  wire logic       ior_n,
  input  wire logic       iow_n,
  input  wire logic [7:0] bus_data_in,
  output      logic [7:0] bus_data_out,
  output      logic       bus_data_oe,
  input  wire logic       busy,
  input  wire logic       ack_n,
  input  wire logic       paper_end,
  input  wire logic       printer_selected,
  input  wire logic       fault_n,
  input  wire logic       direction_mode_pin,
  output      logic       strobe_n,
  output      logic       auto_feed_n,
  output      logic       init,
  output      logic       select_in_n,
  output      logic       printer_data_in_mode,
  output      logic       parport_interrupt
);

  ppri_pkg::ppri_state_s st_q;
  ppri_pkg::ppri_state_s st_d;
  logic [2:0]            fall;
  logic                  rd_start;
  logic                  wr_start;
  logic                  ack_fall;
  logic [7:0]            status_val;
  logic [7:0]            readback_val;

  // ========================================================================
  // Strobe and acknowledge edges
  ppri_fall_detect #(
    .W (3)
  ) u_edges (
    .clk   (clk),
    .rst   (rst),
    .level ({ack_n, iow_n, ior_n}),
    .fall  (fall)
  );

  assign rd_start = fall[0] & ~cs_n;
  assign wr_start = fall[1] & ~cs_n;
  assign ack_fall = fall[2];

  // ========================================================================
  // Read values
  always_comb
  begin
    status_val                      = 8'h00;
    status_val[`PPRI_ST_BUSY_N]     = ~busy;
    status_val[`PPRI_ST_ACK]        = ack_n;
    status_val[`PPRI_ST_PAPER_END]  = paper_end;
    status_val[`PPRI_ST_SELECTED]   = printer_selected;
    status_val[`PPRI_ST_FAULT]      = fault_n;
    // Without software direction control there is no pending indication.
    status_val[`PPRI_ST_IRQ_IDLE]   = ~(st_q.pending & SW_DIR_VARIANT);
    status_val[1:0]                 = `PPRI_ST_ONES;
    readback_val                    = 8'h00;
    readback_val[7:5]               = `PPRI_CMD_ONES;
    readback_val[`PPRI_CT_IRQ_EN]   = st_q.irq_en;
    readback_val[`PPRI_CT_SELECT_IN] = ~st_q.select_in_n;
    readback_val[`PPRI_CT_INIT]     = st_q.init;
    readback_val[`PPRI_CT_AUTO_FEED] = ~st_q.auto_feed_n;
    readback_val[`PPRI_CT_STROBE]   = ~st_q.strobe_n;
  end

  // ========================================================================
  // Next state
  always_comb
  begin
    st_d = st_q;
    if (wr_start && addr == `PPRI_OFS_DRIVE)
    begin
      // Bits 7 and 6 of the written byte are dropped.
      st_d.strobe_n    = ~bus_data_in[`PPRI_CT_STROBE];
      st_d.auto_feed_n = ~bus_data_in[`PPRI_CT_AUTO_FEED];
      st_d.init        = bus_data_in[`PPRI_CT_INIT];
      st_d.select_in_n = ~bus_data_in[`PPRI_CT_SELECT_IN];
      st_d.irq_en      = bus_data_in[`PPRI_CT_IRQ_EN];
      st_d.dir_bit     = bus_data_in[`PPRI_CT_DIR_IN];
    end
    if (wr_start && addr == `PPRI_OFS_IOSEL && !direction_mode_pin)
    begin
      // Any other code leaves the direction where it was.
      if (bus_data_in == `PPRI_IOSEL_INPUT)
      begin
        st_d.iosel_in = 1'b1;
      end
      else if (bus_data_in == `PPRI_IOSEL_OUTPUT)
      begin
        st_d.iosel_in = 1'b0;
      end
    end
    if (!SW_DIR_VARIANT)
    begin
      st_d.data_in_mode = direction_mode_pin;
    end
    else if (direction_mode_pin)
    begin
      st_d.data_in_mode = st_d.dir_bit;
    end
    else
    begin
      st_d.data_in_mode = st_d.iosel_in;
    end
    // A new acknowledge edge wins over a status read in the same cycle.
    if (ack_fall)
    begin
      st_d.pending = 1'b1;
    end
    else if (rd_start && addr == `PPRI_OFS_STATUS)
    begin
      st_d.pending = 1'b0;
    end
    st_d.irq_out = st_d.pending & st_d.irq_en;
    if (rd_start)
    begin
      case (addr)
        `PPRI_OFS_STATUS: st_d.rd_data = status_val;
        `PPRI_OFS_DRIVE:  st_d.rd_data = readback_val;
        default:          st_d.rd_data = 8'hFF;
      endcase
    end
    st_d.rd_oe = ~cs_n & ~ior_n;
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q.strobe_n     <= `PPRI_RST_LINE_N;
      st_q.auto_feed_n  <= `PPRI_RST_LINE_N;
      st_q.init         <= `PPRI_RST_INIT;
      st_q.select_in_n  <= `PPRI_RST_LINE_N;
      st_q.irq_en       <= `PPRI_RST_BIT;
      st_q.dir_bit      <= `PPRI_RST_BIT;
      st_q.iosel_in     <= `PPRI_RST_BIT;
      st_q.pending      <= `PPRI_RST_BIT;
      st_q.irq_out      <= `PPRI_RST_BIT;
      st_q.data_in_mode <= `PPRI_RST_BIT;
      st_q.rd_data      <= `PPRI_RST_BYTE;
      st_q.rd_oe        <= `PPRI_RST_BIT;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign strobe_n             = st_q.strobe_n;
  assign auto_feed_n          = st_q.auto_feed_n;
  assign init                 = st_q.init;
  assign select_in_n          = st_q.select_in_n;
  assign printer_data_in_mode = st_q.data_in_mode;
  assign parport_interrupt    = st_q.irq_out;
  assign bus_data_out         = st_q.rd_data;
  assign bus_data_oe          = st_q.rd_oe;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ack_pending_a: assert property (ack_fall |=> st_q.pending)
    else $error("acknowledge edge did not mark pending");
  irq_gate_a: assert property (parport_interrupt == (st_q.pending && st_q.irq_en))
    else $error("interrupt output not equal to pending and enable");
  irq_rise_a: assert property (
    ack_fall && st_q.irq_en && !(wr_start && addr == `PPRI_OFS_DRIVE) |=> parport_interrupt)
    else $error("enabled acknowledge edge did not raise the interrupt");
  status_clear_a: assert property (
    rd_start && addr == `PPRI_OFS_STATUS && !ack_fall |=> !st_q.pending && !parport_interrupt)
    else $error("status read did not clear pending");
  status_bits_a: assert property (
    rd_start && addr == `PPRI_OFS_STATUS |=> bus_data_out[1:0] == 2'b11
      && bus_data_out[7] == !$past(busy) && bus_data_out[6] == $past(ack_n)
      && bus_data_out[2] == !($past(st_q.pending) && SW_DIR_VARIANT))
    else $error("status byte wrong");
  readback_bits_a: assert property (
    rd_start && addr == `PPRI_OFS_DRIVE |=> bus_data_out[7:5] == 3'b111
      && bus_data_out[4] == $past(st_q.irq_en) && bus_data_out[0] == !$past(strobe_n))
    else $error("readback byte wrong");
  drive_write_a: assert property (
    wr_start && addr == `PPRI_OFS_DRIVE |=> strobe_n == !$past(bus_data_in[0])
      && init == $past(bus_data_in[2]) && select_in_n == !$past(bus_data_in[3]))
    else $error("drive write did not update lines");
  dir_bit_a: assert property (
    SW_DIR_VARIANT && wr_start && addr == `PPRI_OFS_DRIVE && direction_mode_pin
      ##1 direction_mode_pin |-> printer_data_in_mode == $past(bus_data_in[5], 1))
    else $error("direction bit not applied");
  iosel_code_a: assert property (
    SW_DIR_VARIANT && wr_start && addr == `PPRI_OFS_IOSEL && !direction_mode_pin
      && bus_data_in == 8'hAA ##1 !direction_mode_pin |-> printer_data_in_mode)
    else $error("code AA did not select input");
  iosel_out_a: assert property (
    SW_DIR_VARIANT && wr_start && addr == `PPRI_OFS_IOSEL && !direction_mode_pin
      && bus_data_in == 8'h55 ##1 !direction_mode_pin |-> !printer_data_in_mode)
    else $error("code 55 did not select output");
  read_drive_a: assert property (!cs_n && !ior_n |=> bus_data_oe [*1])
    else $error("read data not driven");

  pend_cov_c: cover property (ack_fall ##[1:20] (rd_start && addr == `PPRI_OFS_STATUS));
  irq_cov_c: cover property ($rose(parport_interrupt));
  dir_cov_c: cover property ($rose(printer_data_in_mode));

endmodule

// File: verification/ppri_printer_model.sv
// Behavioural printer that answers each strobe falling while idle with a busy period and an acknowledge pulse.
`timescale 1ns/10ps

module ppri_printer_model #(
  parameter int ACK_DELAY = 3,
  parameter int ACK_W     = 2
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       strobe_n,
  input  wire logic [2:0] lines,
  output      logic       busy,
  output      logic       ack_n,
  output      logic       paper_end,
  output      logic       printer_selected,
  output      logic       fault_n
);
  // ==========================================================================
  // Handshake
  int   cnt;
  logic strobe_q;

  // A strobe that falls while a byte is still being taken is ignored, as a slow printer would.
  always @(negedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy     <= 1'b0;
      ack_n    <= 1'b1;
      cnt      <= 0;
      strobe_q <= 1'b1;
    end
    else
    begin
      strobe_q <= strobe_n;
      if (strobe_q && !strobe_n && cnt == 0)
      begin
        busy <= 1'b1;
        cnt  <= 1;
      end
      else if (cnt != 0)
      begin
        cnt <= cnt + 1;
        if (cnt == ACK_DELAY)
          ack_n <= 1'b0;
        if (cnt == ACK_DELAY + ACK_W)
        begin
          ack_n <= 1'b1;
          busy  <= 1'b0;
          cnt   <= 0;
        end
      end
    end
  end

  assign {paper_end, printer_selected, fault_n} = lines;
endmodule

// File: verification/tb.sv
// Self-checking testbench for the printer port register interface.
`timescale 1ns/10ps
`include "ppri_consts.svh"

`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module tb;
  logic       clk, rst, cs_n, ior_n, iow_n, mode_pin, busy, ack_n, pe, sel, flt;
  logic       strobe_n, auto_feed_n, init, select_in_n, in_mode, irq, oe;
  logic [1:0] addr;
  logic [2:0] lines;
  logic [7:0] wdata, rdata, r, d;
  int         fail_count, n_checks, cycles, i;
  logic [7:0] pat [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'hDF, 8'h3A, 8'hC0};

  ppri_regs uut (.clk(clk), .rst(rst), .cs_n(cs_n), .addr(addr), .ior_n(ior_n),
    .iow_n(iow_n), .bus_data_in(wdata), .bus_data_out(rdata), .bus_data_oe(oe),
    .busy(busy), .ack_n(ack_n), .paper_end(pe), .printer_selected(sel), .fault_n(flt),
    .direction_mode_pin(mode_pin), .strobe_n(strobe_n), .auto_feed_n(auto_feed_n),
    .init(init), .select_in_n(select_in_n), .printer_data_in_mode(in_mode),
    .parport_interrupt(irq));

  ppri_printer_model pm (.clk(clk), .rst(rst), .strobe_n(strobe_n), .lines(lines),
    .busy(busy), .ack_n(ack_n), .paper_end(pe), .printer_selected(sel), .fault_n(flt));

  // ==========================================================================
  // Clock, timeout and verdict
  always #10 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================================
  // Bus cycles, one strobe low cycle each so the next access sees it high again
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(negedge clk);
    cs_n  = 1'b0;
    addr  = a;
    wdata = v;
    iow_n = 1'b0;
    @(negedge clk);
    iow_n = 1'b1;
    cs_n  = 1'b1;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(negedge clk);
    cs_n  = 1'b0;
    addr  = a;
    ior_n = 1'b0;
    @(negedge clk);
    `CHK(oe, 1'b1)
    v     = rdata;
    ior_n = 1'b1;
    cs_n  = 1'b1;
  endtask

  // ==========================================================================
  // Tests
  initial
  begin
    clk = 0; rst = 1; cs_n = 1; addr = 0; ior_n = 1; iow_n = 1; wdata = 0;
    mode_pin = 1; lines = 3'h5; fail_count = 0; n_checks = 0; cycles = 0;
    repeat (5) @(negedge clk);
    rst = 0;
    `CHK({strobe_n, auto_feed_n, init, select_in_n, in_mode, irq, oe}, 7'h68)
    rd(`PPRI_OFS_DRIVE, r);
    `CHK(r, 8'hE0)
    for (i = 0; i < 7; i++)
    begin
      d = pat[i];
      wr(`PPRI_OFS_DRIVE, d);
      `CHK({strobe_n, auto_feed_n, init, select_in_n}, {~d[0], ~d[1], d[2], ~d[3]})
      `CHK(in_mode, d[5])
      rd(`PPRI_OFS_DRIVE, r);
      `CHK(r, {3'h7, d[4:0]})
    end
    // Writing the read-only status place must leave the drive lines alone.
    wr(`PPRI_OFS_STATUS, 8'h0F);
    `CHK({strobe_n, auto_feed_n, init, select_in_n}, 4'hD)
    rd(`PPRI_OFS_IOSEL, r);
    `CHK(r, 8'hFF)
    repeat (8) @(negedge clk);
    rd(`PPRI_OFS_STATUS, r);
    `CHK(r, 8'hEB)
    // Enabled interrupt from a strobe and acknowledge, cleared by a status read.
    wr(`PPRI_OFS_DRIVE, 8'h11);
    repeat (8) @(negedge clk);
    `CHK(irq, 1'b1)
    rd(`PPRI_OFS_STATUS, r);
    `CHK(r, 8'hEB)
    `CHK(irq, 1'b0)
    rd(`PPRI_OFS_STATUS, r);
    `CHK(r, 8'hEF)
    // Masked interrupt stays quiet until the mask opens while still pending.
    lines = 3'h2;
    // The strobe is still low here; raise it so the next write makes a fresh fall.
    wr(`PPRI_OFS_DRIVE, 8'h00);
    wr(`PPRI_OFS_DRIVE, 8'h01);
    repeat (8) @(negedge clk);
    `CHK(irq, 1'b0)
    wr(`PPRI_OFS_DRIVE, 8'h30);
    `CHK(irq, 1'b1)
    `CHK(in_mode, 1'b1)
    rd(`PPRI_OFS_STATUS, r);
    `CHK(r, 8'hD3)
    `CHK(irq, 1'b0)
    // Pin low: only the two direction codes move the data lines.
    mode_pin = 0;
    repeat (2) @(negedge clk);
    `CHK(in_mode, 1'b0)
    wr(`PPRI_OFS_DRIVE, 8'h20);
    `CHK(in_mode, 1'b0)
    wr(`PPRI_OFS_IOSEL, 8'hAA);
    `CHK(in_mode, 1'b1)
    wr(`PPRI_OFS_IOSEL, 8'h5A);
    `CHK(in_mode, 1'b1)
    wr(`PPRI_OFS_IOSEL, 8'h55);
    `CHK(in_mode, 1'b0)
    results();
  end
endmodule
